/* src/prcc_pkg.sv */
`default_nettype none
package prcc_pkg;
  // Register byte addresses on the serial port
  localparam logic [12:0] ADDR_PLL_CTRL = 13'h0010;
  localparam logic [12:0] ADDR_ABL_CTRL = 13'h0017;
  localparam logic [12:0] ADDR_REF_OFS = 13'h0018;
  localparam logic [12:0] ADDR_REF_SEL = 13'h001C;
  localparam logic [12:0] ADDR_PLL_STAT = 13'h001F;
  localparam logic [12:0] ADDR_VCO_DIV = 13'h01E0;
  localparam logic [12:0] ADDR_DIST_SRC = 13'h01E1;
  // Reset values
  localparam logic [7:0] RST_PLL_CTRL = 8'h01;
  localparam logic [7:0] RST_ABL_CTRL = 8'h00;
  localparam logic [7:0] RST_REF_OFS = 8'h00;
  localparam logic [7:0] RST_REF_SEL = 8'h00;
  localparam logic [7:0] RST_VCO_DIV = 8'h00;
  localparam logic [7:0] RST_DIST_SRC = 8'h00;
  // Field positions
  localparam int PWR_LSB = 0;
  localparam int CPMODE_LSB = 2;
  localparam int CPCUR_LSB = 4;
  localparam int POL_BIT = 7;
  localparam int ABL_LSB = 0;
  localparam int DCOFS_BIT = 7;
  localparam int DIFF_BIT = 0;
  localparam int FIRST_SINGLE_ENDED_REFERENCE_EN_BIT = 1;
  localparam int SECOND_SINGLE_ENDED_REFERENCE_EN_BIT = 2;
  localparam int XTAL_BIT = 3;
  localparam int DBL_BIT = 4;
  localparam int VDIV_LSB = 0;
  localparam int BYPASS_BIT = 0;
  localparam int CLKSEL_BIT = 1;
  // PLL power codes
  localparam logic [1:0] PWR_ON = 2'h0;
  localparam logic [1:0] PWR_OFF = 2'h1;
  typedef enum logic [1:0] {CP_HIZ = 2'h0, CP_UP = 2'h1, CP_DOWN = 2'h2,
    CP_NORMAL = 2'h3} prcc_cp_mode_t;
  typedef enum logic [1:0] {PFD_IDLE = 2'h0, PFD_UP = 2'h1, PFD_BOTH = 2'h3,
    PFD_DOWN = 2'h2} prcc_pfd_state_t;
  // Serial frame layout
  localparam logic [4:0] INSTR_LAST = 5'h0F;
  localparam logic [4:0] FRAME_LAST = 5'h17;
  localparam logic [4:0] FRAME_DONE = 5'h18;
  localparam int RW_BIT = 15;
  // Timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int ABL_STEP_NS = 20;
  localparam int ABL_STEP_CYC = (ABL_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Divider code to ratio; codes 6 and 7 fall back to two
  function automatic logic [2:0] vcoRatioOf(input logic [2:0] code);
    if (code <= 3'h4) return code + 3'h2;
    else if (code == 3'h5) return 3'h1;
    else return 3'h2;
  endfunction : vcoRatioOf

  function automatic logic [3:0] cpStepsOf(input logic [2:0] code);
    return {1'b0, code} + 4'h1;
  endfunction : cpStepsOf

  function automatic logic [7:0] ablCyclesOf(input logic [1:0] sel);
    return 8'(({6'h00, sel} + 8'h01) * ABL_STEP_CYC);
  endfunction : ablCyclesOf
endpackage : prcc_pkg
`default_nettype wire

/* src/prcc_serial_port.sv */
`default_nettype none
module prcc_serial_port
  import prcc_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic sclk,
  input wire logic csN,
  input wire logic sdi,
  output logic sdo,
  output logic sdoEn,
  output logic [12:0] addr,
  input wire logic [7:0] rdData,
  output logic wrStrobe,
  output logic [7:0] wrData
);
  logic [2:0] sync1, sync2, sync3, pinLvl, pinPrev;
  logic [4:0] bitCnt;
  logic [15:0] shiftIn;
  logic isRead, loadTx;
  logic [7:0] txShift;
  logic sclkRise, sclkFall, csActive;

  // Three stages per pin; a level counts once stages two and three agree
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      sync1 <= 3'h2;
      sync2 <= 3'h2;
      sync3 <= 3'h2;
      pinLvl <= 3'h2;
      pinPrev <= 3'h2;
    end else begin
      sync1 <= {sclk, csN, sdi};
      sync2 <= sync1;
      sync3 <= sync2;
      pinLvl <= (~(sync2 ^ sync3) & sync2) | ((sync2 ^ sync3) & pinLvl);
      pinPrev <= pinLvl;
    end
  end

  assign sclkRise = pinLvl[2] & ~pinPrev[2];
  assign sclkFall = ~pinLvl[2] & pinPrev[2];
  assign csActive = ~pinLvl[1];

  // Frame receive: 16 instruction bits, then one data byte, MSB first
  always_ff @(posedge mclk) begin
    if (!nrst || !csActive) begin
      bitCnt <= 5'h00;
      shiftIn <= 16'h0000;
      isRead <= 1'b0;
      loadTx <= 1'b0;
      wrStrobe <= 1'b0;
      wrData <= 8'h00;
      if (!nrst) addr <= 13'h0000;
    end else begin
      loadTx <= 1'b0;
      wrStrobe <= 1'b0;
      if (sclkRise && bitCnt != FRAME_DONE) begin
        shiftIn <= {shiftIn[14:0], pinLvl[0]};
        bitCnt <= bitCnt + 5'h01;
        if (bitCnt == INSTR_LAST) begin
          addr <= {shiftIn[11:0], pinLvl[0]};
          isRead <= shiftIn[RW_BIT - 1];
          loadTx <= shiftIn[RW_BIT - 1];
        end
        // Extra bytes after the first are ignored; no address stepping
        if (bitCnt == FRAME_LAST && !isRead) begin
          wrStrobe <= 1'b1;
          wrData <= {shiftIn[6:0], pinLvl[0]};
        end
      end
    end
  end

  // Read data leave on falling edges so the master samples on rising ones
  always_ff @(posedge mclk) begin
    if (!nrst || !csActive) begin
      txShift <= 8'h00;
      sdo <= 1'b0;
      sdoEn <= 1'b0;
    end else if (loadTx) begin
      txShift <= rdData;
      sdoEn <= 1'b1;
    end else if (sclkFall && isRead) begin
      sdo <= txShift[7];
      txShift <= {txShift[6:0], 1'b0};
    end
  end
endmodule : prcc_serial_port
`default_nettype wire

/* src/prcc_top.sv */
// Summary of operation
// R01: Reset loads the PLL power field with the off code.
// R02: Divider ratio field resets to zero, meaning divide by two.
// R03: Source select resets to divider path; ratios one to six available.
// R04: Software keeps channel divider input within its frequency limit.
// R05: Writing the on code to the power field runs the PLL.
// R06: Polarity bit picks positive or negative phase detector sense.
// R07: Two-bit field sets antibacklash pulse width.
// R08: Pump mode field: high impedance, normal, forced up, forced down.
// R09: Pump current programmable in eight steps.
// R10: Detector compares reference and feedback, commands pump up or down.
// R11: PLL on with default routing feeds oscillator straight to prescaler.
// R12: All reference inputs disabled after reset until software enables one.
// R13: Reference input type chosen by bits of one reference register.
// R14: Offset bit shifts single-ended bias point downward.
// R15: Differential receiver off unless selected and PLL powered.
// R16: Each single-ended buffer off with PLL down or own bit.
// R17: Differential mode forces both single-ended buffers off.
// R18: Crystal enable bit turns on the maintaining amplifier.
// R19: Optional reference doubler can be enabled.
// R20: Pump current code is three bits, one to eight steps linearly.
`default_nettype none
module prcc_top
  import prcc_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic sclk,
  input wire logic csN,
  input wire logic sdi,
  output logic sdo,
  output logic sdoEn,
  input wire logic refDivIn,
  input wire logic fbDivIn,
  output logic pllPowerDown,
  output logic pfdNegative,
  output logic [1:0] cpMode,
  output logic [3:0] cpCurrentSteps,
  output logic [1:0] antibacklashSel,
  output logic refDcOffsetShift,
  output logic diffRxPowerDown,
  output logic ref1BufPowerDown,
  output logic ref2BufPowerDown,
  output logic crystalAmpEnable,
  output logic refDoublerEnable,
  output logic [2:0] vcoDivRatio,
  output logic vcoDivBypass,
  output logic distClkSelect,
  output logic prescalerDirect,
  output logic pumpUp,
  output logic pumpDown
);
  localparam logic [7:0] ABL_MAX = ablCyclesOf(2'h3);

  logic [7:0] pllCtrlReg, ablCtrlReg, refOfsReg, refSelReg;
  logic [7:0] vcoDivReg, distSrcReg;
  logic [12:0] busAddr;
  logic [7:0] rdData, wrData;
  logic wrStrobe;
  logic pllOn, polNeg, diffSel;
  prcc_cp_mode_t cpModeNow;
  logic [1:0] edgeSync1, edgeSync2, edgeSync3, edgeLvl, edgePrev;
  logic refRise, fbRise, upEv, dnEv;
  prcc_pfd_state_t pfdState, pfdNext;
  logic [7:0] ablCnt, ablCntNext;
  logic [7:0] bothRun;

  // Serial control port; only path to the registers
  prcc_serial_port u_port (
    .mclk(mclk),
    .nrst(nrst),
    .sclk(sclk),
    .csN(csN),
    .sdi(sdi),
    .sdo(sdo),
    .sdoEn(sdoEn),
    .addr(busAddr),
    .rdData(rdData),
    .wrStrobe(wrStrobe),
    .wrData(wrData)
  );

  // Register file; reset values give distribution-only with PLL off
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      pllCtrlReg <= RST_PLL_CTRL; // R01
      ablCtrlReg <= RST_ABL_CTRL;
      refOfsReg <= RST_REF_OFS;
      refSelReg <= RST_REF_SEL; // R12
      vcoDivReg <= RST_VCO_DIV; // R02
      distSrcReg <= RST_DIST_SRC; // R03
    end else if (wrStrobe) begin
      case (busAddr)
        ADDR_PLL_CTRL: pllCtrlReg <= wrData; // R05
        ADDR_ABL_CTRL: ablCtrlReg <= wrData;
        ADDR_REF_OFS: refOfsReg <= wrData;
        ADDR_REF_SEL: refSelReg <= wrData; // R13
        ADDR_VCO_DIV: vcoDivReg <= wrData;
        ADDR_DIST_SRC: distSrcReg <= wrData;
        default: ;
      endcase
    end
  end

  // Read-back; unmapped addresses return zero, status is read-only
  always_comb begin
    rdData = 8'h00;
    case (busAddr)
      ADDR_PLL_CTRL: rdData = pllCtrlReg;
      ADDR_ABL_CTRL: rdData = ablCtrlReg;
      ADDR_REF_OFS: rdData = refOfsReg;
      ADDR_REF_SEL: rdData = refSelReg;
      ADDR_PLL_STAT: rdData = {3'h0, pumpDown, pumpUp, pfdState, pllPowerDown};
      ADDR_VCO_DIV: rdData = vcoDivReg;
      ADDR_DIST_SRC: rdData = distSrcReg;
      default: rdData = 8'h00;
    endcase
  end

  // Decoded control fields
  assign pllOn = pllCtrlReg[PWR_LSB +: 2] == PWR_ON; // R05
  assign polNeg = pllCtrlReg[POL_BIT];
  assign cpModeNow = prcc_cp_mode_t'(pllCtrlReg[CPMODE_LSB +: 2]);
  assign diffSel = refSelReg[DIFF_BIT];

  // Analog control outputs, all registered to keep the pins glitch free
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      pllPowerDown <= 1'b1;
      pfdNegative <= 1'b0;
      cpMode <= 2'h0;
      cpCurrentSteps <= 4'h1;
      antibacklashSel <= 2'h0;
      refDcOffsetShift <= 1'b0;
      crystalAmpEnable <= 1'b0;
      refDoublerEnable <= 1'b0;
    end else begin
      // Codes other than on, including the reserved ones, keep it down
      pllPowerDown <= !pllOn; // R01
      pfdNegative <= polNeg; // R06
      cpMode <= pllCtrlReg[CPMODE_LSB +: 2]; // R08
      cpCurrentSteps <= cpStepsOf(pllCtrlReg[CPCUR_LSB +: 3]); // R09 R20
      antibacklashSel <= ablCtrlReg[ABL_LSB +: 2]; // R07
      refDcOffsetShift <= refOfsReg[DCOFS_BIT]; // R14
      crystalAmpEnable <= refSelReg[XTAL_BIT]; // R18
      refDoublerEnable <= refSelReg[DBL_BIT]; // R19
    end
  end

  // Reference input power gating
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      diffRxPowerDown <= 1'b1;
      ref1BufPowerDown <= 1'b1;
      ref2BufPowerDown <= 1'b1;
    end else begin
      diffRxPowerDown <= !diffSel || !pllOn; // R15
      // Differential mode wins over the single-ended enables
      ref1BufPowerDown <= !pllOn || diffSel || !refSelReg[FIRST_SINGLE_ENDED_REFERENCE_EN_BIT]; // R16 R17
      ref2BufPowerDown <= !pllOn || diffSel || !refSelReg[SECOND_SINGLE_ENDED_REFERENCE_EN_BIT]; // R16 R17
    end
  end

  // Clock routing toward the distribution section and prescaler
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      vcoDivRatio <= 3'h2;
      vcoDivBypass <= 1'b0;
      distClkSelect <= 1'b0;
      prescalerDirect <= 1'b0;
    end else begin
      vcoDivRatio <= vcoRatioOf(vcoDivReg[VDIV_LSB +: 3]); // R02 R03
      vcoDivBypass <= distSrcReg[BYPASS_BIT]; // R03
      distClkSelect <= distSrcReg[CLKSEL_BIT];
      prescalerDirect <= pllOn && !distSrcReg[BYPASS_BIT]; // R11
    end
  end

  // Divider outputs arrive from another domain: three stages each
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      edgeSync1 <= 2'h0;
      edgeSync2 <= 2'h0;
      edgeSync3 <= 2'h0;
      edgeLvl <= 2'h0;
      edgePrev <= 2'h0;
    end else begin
      edgeSync1 <= {fbDivIn, refDivIn};
      edgeSync2 <= edgeSync1;
      edgeSync3 <= edgeSync2;
      edgeLvl <= (~(edgeSync2 ^ edgeSync3) & edgeSync2)
        | ((edgeSync2 ^ edgeSync3) & edgeLvl);
      edgePrev <= edgeLvl;
    end
  end

  assign refRise = edgeLvl[0] & ~edgePrev[0];
  assign fbRise = edgeLvl[1] & ~edgePrev[1];
  // Negative sense swaps which input leads to pumping up
  assign upEv = polNeg ? fbRise : refRise; // R06 R10
  assign dnEv = polNeg ? refRise : fbRise; // R06 R10

  // Detector next state; edges during the reset pulse are dropped
  always_comb begin
    pfdNext = pfdState;
    ablCntNext = ablCnt;
    if (!pllOn) begin
      pfdNext = PFD_IDLE;
      ablCntNext = 8'h00;
    end else begin
      unique case (pfdState)
        PFD_IDLE: begin
          if (upEv && dnEv) begin
            pfdNext = PFD_BOTH;
            ablCntNext = ablCyclesOf(ablCtrlReg[ABL_LSB +: 2]); // R07
          end else if (upEv) begin
            pfdNext = PFD_UP; // R10
          end else if (dnEv) begin
            pfdNext = PFD_DOWN; // R10
          end
        end
        PFD_UP: begin
          if (dnEv) begin
            pfdNext = PFD_BOTH;
            ablCntNext = ablCyclesOf(ablCtrlReg[ABL_LSB +: 2]); // R07
          end
        end
        PFD_DOWN: begin
          if (upEv) begin
            pfdNext = PFD_BOTH;
            ablCntNext = ablCyclesOf(ablCtrlReg[ABL_LSB +: 2]); // R07
          end
        end
        PFD_BOTH: begin
          // Both sides stay on for the antibacklash width, then release
          if (ablCnt <= 8'h01) begin
            pfdNext = PFD_IDLE;
            ablCntNext = 8'h00;
          end else begin
            ablCntNext = ablCnt - 8'h01;
          end
        end
      endcase
    end
  end

  // Detector state
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      pfdState <= PFD_IDLE;
      ablCnt <= 8'h00;
    end else begin
      pfdState <= pfdNext;
      ablCnt <= ablCntNext;
    end
  end

  // Pump commands; test modes override the detector, high-Z drives both off
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      pumpUp <= 1'b0;
      pumpDown <= 1'b0;
    end else if (!pllOn) begin
      pumpUp <= 1'b0;
      pumpDown <= 1'b0;
    end else begin
      unique case (cpModeNow)
        CP_HIZ: begin
          pumpUp <= 1'b0; // R08
          pumpDown <= 1'b0;
        end
        CP_UP: begin
          pumpUp <= 1'b1; // R08
          pumpDown <= 1'b0;
        end
        CP_DOWN: begin
          pumpUp <= 1'b0; // R08
          pumpDown <= 1'b1;
        end
        CP_NORMAL: begin
          pumpUp <= pfdState == PFD_UP || pfdState == PFD_BOTH; // R10
          pumpDown <= pfdState == PFD_DOWN || pfdState == PFD_BOTH; // R10
        end
      endcase
    end
  end

  // Helper: length of the current overlap of both pump commands
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      bothRun <= 8'h00;
    end else if (pumpUp && pumpDown && cpModeNow == CP_NORMAL) begin
      bothRun <= bothRun + 8'h01;
    end else begin
      bothRun <= 8'h00;
    end
  end

  chk_reset_defaults: assert property ( // R01
    @(posedge mclk) disable iff (!nrst)
    $rose(nrst) |-> pllCtrlReg[PWR_LSB +: 2] == PWR_OFF && vcoDivReg == 8'h00
      && distSrcReg == 8'h00 && refSelReg == 8'h00
  ) else $error("registers not at reset defaults after reset");

  chk_reset_outputs: assert property ( // R12
    @(posedge mclk) disable iff (!nrst)
    $rose(nrst) ##1 !wrStrobe |-> pllPowerDown && diffRxPowerDown
      && ref1BufPowerDown && ref2BufPowerDown && !pumpUp && !pumpDown
  ) else $error("reference inputs or PLL awake after reset");

  chk_pll_enable: assert property ( // R05
    @(posedge mclk) disable iff (!nrst)
    wrStrobe && busAddr == ADDR_PLL_CTRL && wrData[PWR_LSB +: 2] == PWR_ON
      |-> ##2 !pllPowerDown
  ) else $error("PLL not enabled two cycles after on code written");

  chk_divider_ratio: assert property ( // R02
    @(posedge mclk) disable iff (!nrst)
    $past(vcoDivReg[VDIV_LSB +: 3]) == 3'h0 && !$rose(nrst) |-> vcoDivRatio == 3'h2
  ) else $error("divider code zero did not give ratio two");

  chk_se_power_gate: assert property ( // R16
    @(posedge mclk) disable iff (!nrst)
    pllPowerDown |-> ref1BufPowerDown && ref2BufPowerDown && diffRxPowerDown
  ) else $error("reference buffer on while PLL is down");

  chk_diff_forces_se: assert property ( // R17
    @(posedge mclk) disable iff (!nrst)
    !diffRxPowerDown |-> ref1BufPowerDown && ref2BufPowerDown
  ) else $error("single-ended buffer on in differential mode");

  chk_hiz_holds: assert property ( // R08
    @(posedge mclk) disable iff (!nrst)
    $past(cpModeNow) == CP_HIZ && !$rose(nrst) |-> !pumpUp && !pumpDown
  ) else $error("pump active in high impedance mode");

  chk_abl_width: assert property ( // R07
    @(posedge mclk) disable iff (!nrst)
    bothRun <= ABL_MAX
  ) else $error("antibacklash overlap longer than widest setting");

  chk_pfd_up_edge: assert property ( // R10
    @(posedge mclk) disable iff (!nrst)
    pllOn && cpModeNow == CP_NORMAL && pfdState == PFD_IDLE && upEv && !dnEv
      ##1 pllOn && cpModeNow == CP_NORMAL |=> pumpUp && !pumpDown
  ) else $error("leading edge did not command pump up");

  chk_prescaler_path: assert property ( // R11
    @(posedge mclk) disable iff (!nrst)
    prescalerDirect |-> !pllPowerDown && !vcoDivBypass
  ) else $error("prescaler fed directly outside default routing");

  chk_pump_steps: assert property ( // R20
    @(posedge mclk) disable iff (!nrst)
    !$rose(nrst) |-> cpCurrentSteps == {1'b0, $past(pllCtrlReg[CPCUR_LSB +: 3])} + 4'h1
  ) else $error("pump current steps do not follow the code");
endmodule : prcc_top
`default_nettype wire

/* dv/prcc_ref_model.sv */
`default_nettype none
module prcc_ref_model #(
  parameter int PERIOD = 64,
  parameter int LAG = 10
) (
  input wire logic mclk,
  input wire logic run,
  output logic refDivIn,
  output logic fbDivIn
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;

  // Both dividers sit low while stopped, so no stray edge reaches the detector
  always @(posedge mclk) begin
    if (!run) begin
      cnt <= 0;
      refDivIn <= 1'b0;
      fbDivIn <= 1'b0;
    end else begin
      cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
      refDivIn <= (cnt >= 2) && (cnt < 2 + PERIOD / 2);
      // Feedback lags the reference: oscillator kept inside the prescaler range
      fbDivIn <= (cnt >= 2 + LAG) && (cnt < 2 + LAG + PERIOD / 2);
    end
  end
endmodule : prcc_ref_model
`default_nettype wire

/* dv/testbench.sv */
`default_nettype none
module testbench;
  import prcc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LIMIT = 60000;
  logic mclk, nrst, sclk, csN, sdi, sdo, sdoEn, refDivIn, fbDivIn, run;
  logic pllPowerDown, pfdNegative, refDcOffsetShift, diffRxPowerDown;
  logic ref1BufPowerDown, ref2BufPowerDown, crystalAmpEnable, refDoublerEnable;
  logic vcoDivBypass, distClkSelect, prescalerDirect, pumpUp, pumpDown;
  logic [1:0] cpMode, antibacklashSel;
  logic [3:0] cpCurrentSteps;
  logic [2:0] vcoDivRatio;
  logic [7:0] rq;
  int err_total, cmp_count, cyc;
  logic [7:0] refVal [7] = '{8'h01, 8'h07, 8'h02, 8'h04, 8'h06, 8'h06, 8'h18};
  logic [7:0] pllVal [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00};
  logic [4:0] refExp [7] = '{5'h0C, 5'h0C, 5'h14, 5'h18, 5'h10, 5'h1C, 5'h1F};

  prcc_top i_dut (.mclk(mclk), .nrst(nrst), .sclk(sclk), .csN(csN), .sdi(sdi),
    .sdo(sdo), .sdoEn(sdoEn), .refDivIn(refDivIn), .fbDivIn(fbDivIn),
    .pllPowerDown(pllPowerDown), .pfdNegative(pfdNegative), .cpMode(cpMode),
    .cpCurrentSteps(cpCurrentSteps), .antibacklashSel(antibacklashSel),
    .refDcOffsetShift(refDcOffsetShift), .diffRxPowerDown(diffRxPowerDown),
    .ref1BufPowerDown(ref1BufPowerDown), .ref2BufPowerDown(ref2BufPowerDown),
    .crystalAmpEnable(crystalAmpEnable), .refDoublerEnable(refDoublerEnable),
    .vcoDivRatio(vcoDivRatio), .vcoDivBypass(vcoDivBypass),
    .distClkSelect(distClkSelect), .prescalerDirect(prescalerDirect),
    .pumpUp(pumpUp), .pumpDown(pumpDown));

  prcc_ref_model i_ref (.mclk(mclk), .run(run), .refDivIn(refDivIn), .fbDivIn(fbDivIn));

  // Free running system clock
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  task automatic complete_run();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : complete_run

  // Hang guard, sized at about three times the expected run
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      err_total++;
      complete_run();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // One serial frame; sclk half period of 6 mclk keeps the synchroniser happy
  task automatic frame(input logic rd, input logic [12:0] a, input logic [7:0] d,
      output logic [7:0] q);
    logic [23:0] w;
    w = {rd, 2'b00, a, d};
    q = 8'h00;
    @(negedge mclk) csN = 1'b0;
    repeat (4) @(negedge mclk);
    for (int i = 23; i >= 0; i--) begin
      sclk = 1'b0;
      sdi = w[i];
      repeat (6) @(negedge mclk);
      // Read bit settles about 4 mclk after the fall, taken just before the rise
      if (i < 8) q[i] = sdo;
      if (rd && i == 4) check({7'h00, sdoEn}, 8'h01);
      sclk = 1'b1;
      repeat (6) @(negedge mclk);
    end
    sclk = 1'b0;
    repeat (2) @(negedge mclk);
    csN = 1'b1;
    repeat (8) @(negedge mclk);
  endtask : frame

  // Outputs follow a write within a few mclk of the frame end
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    frame(1'b0, a, d, rq);
    repeat (10) @(negedge mclk);
  endtask : wr

  task automatic rdchk(input logic [12:0] a, input logic [7:0] exp);
    frame(1'b1, a, 8'h00, rq);
    check(rq, exp);
  endtask : rdchk

  // Lets the model start a fresh ref/fb pair and measures first pump and overlap
  task automatic pfd(input logic [1:0] expPair, input logic [1:0] sel);
    int n;
    run = 1'b1;
    n = 0;
    while ((pumpUp | pumpDown) !== 1'b1 && n < 40) begin
      @(negedge mclk);
      n++;
    end
    check({6'h00, pumpUp, pumpDown}, {6'h00, expPair});
    n = 0;
    while (!(pumpUp === 1'b1 && pumpDown === 1'b1) && n < 40) begin
      @(negedge mclk);
      n++;
    end
    n = 0;
    while (pumpUp === 1'b1 && pumpDown === 1'b1 && n < 20) begin
      @(negedge mclk);
      n++;
    end
    check(8'(n), {6'h00, sel} + 8'h01);
    run = 1'b0;
    repeat (80) @(negedge mclk);
  endtask : pfd

  initial begin
    nrst = 1'b0;
    sclk = 1'b0;
    csN = 1'b1;
    sdi = 1'b0;
    run = 1'b0;
    err_total = 0;
    cmp_count = 0;
    cyc = 0;
    repeat (3) @(negedge mclk);
    nrst = 1'b1;
    repeat (6) @(negedge mclk);

    // Defaults after reset, at the pins and in the registers
    check({7'h00, pllPowerDown}, 8'h01);
    check({5'h00, vcoDivRatio}, 8'h02);
    check({6'h00, vcoDivBypass, distClkSelect}, 8'h00);
    check({3'h00, diffRxPowerDown, ref1BufPowerDown, ref2BufPowerDown,
      crystalAmpEnable, prescalerDirect}, 8'h1C);
    check({4'h0, cpCurrentSteps}, 8'h01);
    rdchk(ADDR_PLL_CTRL, 8'h01);
    rdchk(ADDR_VCO_DIV, 8'h00);
    rdchk(ADDR_DIST_SRC, 8'h00);
    rdchk(ADDR_REF_SEL, 8'h00);
    rdchk(ADDR_ABL_CTRL, 8'h00);
    rdchk(ADDR_REF_OFS, 8'h00);
    rdchk(13'h0123, 8'h00);
    rdchk(ADDR_PLL_STAT, 8'h01);
    $display("test reset_defaults done");

    // Pump current, pump mode and polarity swept together with the PLL on
    for (int c = 0; c < 8; c++) begin
      wr(ADDR_PLL_CTRL, {c[0], c[2:0], c[1:0], 2'b00});
      check({4'h0, cpCurrentSteps}, 8'(c + 1));
      check({6'h00, cpMode}, {6'h00, c[1:0]});
      // Test modes drive the pump at once; no detector edges arrive here
      check({6'h00, pumpUp, pumpDown}, {6'h00, c[1:0] == 2'h1, c[1:0] == 2'h2});
      check({6'h00, pfdNegative, pllPowerDown}, {6'h00, c[0], 1'b0});
      rdchk(ADDR_PLL_CTRL, {c[0], c[2:0], c[1:0], 2'b00});
    end
    $display("test pump_settings done");

    // Reference input power table, including the PLL off case
    for (int k = 0; k < 7; k++) begin
      wr(ADDR_PLL_CTRL, pllVal[k]);
      wr(ADDR_REF_SEL, refVal[k]);
      check({3'h0, diffRxPowerDown, ref1BufPowerDown, ref2BufPowerDown,
        crystalAmpEnable, refDoublerEnable}, {3'h0, refExp[k]});
    end
    rdchk(ADDR_REF_SEL, 8'h18);
    wr(ADDR_REF_OFS, 8'h80);
    check({7'h00, refDcOffsetShift}, 8'h01);
    rdchk(ADDR_REF_OFS, 8'h80);
    $display("test reference_inputs done");

    // Divider ratios and routing; the bypass is set only with the divider path known
    for (int c = 0; c < 8; c++) begin
      wr(ADDR_VCO_DIV, 8'(c));
      check({5'h00, vcoDivRatio}, (c < 5) ? 8'(c + 2) : ((c == 5) ? 8'h01 : 8'h02));
    end
    wr(ADDR_PLL_CTRL, 8'h00);
    check({7'h00, prescalerDirect}, 8'h01);
    // Status is read-only: the write must leave the live PLL state visible
    wr(ADDR_PLL_STAT, 8'hFF);
    rdchk(ADDR_PLL_STAT, 8'h00);
    wr(ADDR_DIST_SRC, 8'h01);
    check({5'h00, vcoDivBypass, distClkSelect, prescalerDirect}, 8'h04);
    wr(ADDR_DIST_SRC, 8'h02);
    check({5'h00, vcoDivBypass, distClkSelect, prescalerDirect}, 8'h03);
    rdchk(ADDR_DIST_SRC, 8'h02);
    $display("test divider_routing done");

    // Detector ordering and overlap width for each setting and both senses
    for (int s = 0; s < 4; s++) begin
      wr(ADDR_ABL_CTRL, 8'(s));
      check({6'h00, antibacklashSel}, 8'(s));
      wr(ADDR_PLL_CTRL, {s[0], 3'h0, 2'b11, 2'b00});
      pfd(s[0] ? 2'b01 : 2'b10, 2'(s));
    end
    // Powered-down PLL keeps both pump commands idle
    wr(ADDR_PLL_CTRL, 8'h0D);
    run = 1'b1;
    repeat (70) @(negedge mclk);
    check({6'h00, pumpUp, pumpDown}, 8'h00);
    run = 1'b0;
    $display("test phase_detector done");

    // Reset again mid-run: every register returns to its default
    nrst = 1'b0;
    repeat (3) @(negedge mclk);
    nrst = 1'b1;
    repeat (6) @(negedge mclk);
    check({2'h0, cpMode, antibacklashSel, distClkSelect, crystalAmpEnable}, 8'h00);
    check({6'h00, pllPowerDown, refDoublerEnable}, 8'h02);
    rdchk(ADDR_REF_SEL, 8'h00);
    rdchk(ADDR_PLL_CTRL, 8'h01);
    $display("test mid_reset done");
    complete_run();
  end
endmodule : testbench
`default_nettype wire
